// *** hdl/tfq_alarm_core.sv ***
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
// How it works
// - continuous conversion overwrites the stored result after every completed conversion
// - the stored result can be read at any time, even mid-conversion
// - two resolution bits pick 9, 10, 11 or 12 result bits
// - resolution comes out of any reset at nine bits
// - every new stored result is checked against both limits
// - alarm output is active low by default; polarity bit 1 makes it high
// - mode bit picks comparator or interrupt alarm; comparator by default
// - a fault is a result at or above high, or at or below low
// - queue field needs 1, 2, 4 or 6 consecutive faults
// - each fault bumps the counter (held at 7), reaching the setting gives a valid fault condition
// - a result that is not a fault clears the counter
// - comparator alarm sets on a valid fault at the upper limit
// - comparator alarm clears only on a later valid fault at or below low, or on a general call reset
// - in comparator mode reads, writes and shutdown leave the alarm alone
// - switching to comparator with alarm active keeps it until a low fault
// - general call reset clears alarm and restores configuration defaults
// - interrupt alarm holds until a read, alert answer or shutdown entry
// - shutdown neither clears nor changes the fault counter
module tfq_alarm_core
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic [1:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	input wire logic i_conv_valid,
	input wire logic [11:0] i_conv_data,
	output logic o_conv_run,
	input wire logic i_gc_reset,
	input wire logic i_ara_ack,
	output logic o_alert
);

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	logic [11:0] temp_q;
	logic [11:0] temp_d;
	logic [11:0] tlow_q;
	logic [11:0] tlow_d;
	logic [11:0] thigh_q;
	logic [11:0] thigh_d;
	logic [7:0] cfg_q;
	logic [7:0] cfg_d;
	logic new_q;
	logic new_d;
	logic oneshot_q;
	logic oneshot_d;
	logic conv_run_q;
	logic conv_run_d;
	logic alarm_q;
	logic alarm_d;
	tfq_pkg::tfq_expect_t expect_q;
	tfq_pkg::tfq_expect_t expect_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic alert_q;
	logic alert_d;

	logic is_high;
	logic is_low;
	logic fault_valid;
	logic accept;
	logic cfg_write;
	logic sd_entry;
	logic int_clear;
	logic thermostat_mode_bit;
	logic alarm_polarity_bit;
	logic shutdown_bit;
	logic [1:0] resolution_sel;
	logic [1:0] queue_sel;

	assign thermostat_mode_bit = cfg_q[tfq_pkg::THERMOSTAT_MODE_BIT_POS];
	assign alarm_polarity_bit = cfg_q[tfq_pkg::ALARM_POLARITY_BIT_POS];
	assign shutdown_bit = cfg_q[tfq_pkg::SHUTDOWN_BIT_POS];
	assign resolution_sel = {cfg_q[tfq_pkg::RESOLUTION_HI_BIT_POS],
		cfg_q[tfq_pkg::RESOLUTION_LO_BIT_POS]};
	assign queue_sel = {cfg_q[tfq_pkg::FAULT_QUEUE_HI_BIT_POS],
		cfg_q[tfq_pkg::FAULT_QUEUE_LO_BIT_POS]};

	// -----------------------------------------------------------------
	// limit check and fault queue
	// -----------------------------------------------------------------
	// compare runs one cycle after the store, on the stored value
	tfq_limit_compare u_compare
	(
		.i_temp(temp_q),
		.i_thigh(thigh_q),
		.i_tlow(tlow_q),
		.o_high(is_high),
		.o_low(is_low)
	);

	tfq_fault_queue u_queue
	(
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_clear(i_gc_reset),
		.i_sample(new_q),
		.i_fault(is_high | is_low),
		.i_queue_sel(queue_sel),
		.o_valid(fault_valid)
	);

	// -----------------------------------------------------------------
	// next-state logic
	// -----------------------------------------------------------------
	always_comb
	begin
		accept = i_conv_valid && conv_run_q;
		cfg_write = i_wr && i_addr == tfq_pkg::ADDR_CFG;
		sd_entry = cfg_write && !shutdown_bit
			&& i_wdata[8 + tfq_pkg::SHUTDOWN_BIT_POS];
		int_clear = thermostat_mode_bit
			&& (i_rd || i_ara_ack || sd_entry);
		temp_d = temp_q;
		tlow_d = tlow_q;
		thigh_d = thigh_q;
		cfg_d = cfg_q;
		oneshot_d = oneshot_q;
		alarm_d = alarm_q;
		expect_d = expect_q;
		new_d = accept;
		rdata_d = tfq_pkg::RDATA_IDLE;

		// reads never disturb the conversion path
		if (i_rd)
		begin
			case (i_addr)
				tfq_pkg::ADDR_TEMP: rdata_d = {temp_q, tfq_pkg::FRAC_ZERO};
				tfq_pkg::ADDR_CFG: rdata_d = {cfg_q, tfq_pkg::CFG_LOW_BYTE};
				tfq_pkg::ADDR_TLOW: rdata_d = {tlow_q, tfq_pkg::FRAC_ZERO};
				tfq_pkg::ADDR_THIGH: rdata_d = {thigh_q, tfq_pkg::FRAC_ZERO};
				default: rdata_d = tfq_pkg::RDATA_IDLE;
			endcase
		end

		// the result register is read only, a write to it is dropped
		if (i_wr)
		begin
			case (i_addr)
				tfq_pkg::ADDR_CFG:
				begin
					cfg_d = i_wdata[15:8];
					cfg_d[tfq_pkg::ONE_SHOT_BIT_POS] = 1'b0;
					if (i_wdata[8 + tfq_pkg::ONE_SHOT_BIT_POS]
						&& i_wdata[8 + tfq_pkg::SHUTDOWN_BIT_POS])
						oneshot_d = 1'b1;
				end
				tfq_pkg::ADDR_TLOW: tlow_d = i_wdata[15:4];
				tfq_pkg::ADDR_THIGH: thigh_d = i_wdata[15:4];
				default: ;
			endcase
		end

		if (accept)
		begin
			temp_d = i_conv_data & tfq_pkg::res_mask(resolution_sel);
			oneshot_d = 1'b0;
		end

		// clear first so that a new interrupt event in the same cycle wins
		if (int_clear)
			alarm_d = 1'b0;
		if (fault_valid)
		begin
			if (!thermostat_mode_bit)
			begin
				// comparator: only limits move the alarm
				if (is_high)
				begin
					alarm_d = 1'b1;
					expect_d = tfq_pkg::EXPECT_LOW;
				end
				else if (is_low)
				begin
					alarm_d = 1'b0;
					expect_d = tfq_pkg::EXPECT_HIGH;
				end
			end
			else if (is_high && expect_q == tfq_pkg::EXPECT_HIGH)
			begin
				alarm_d = 1'b1;
				expect_d = tfq_pkg::EXPECT_LOW;
			end
			else if (is_low && expect_q == tfq_pkg::EXPECT_LOW)
			begin
				alarm_d = 1'b1;
				expect_d = tfq_pkg::EXPECT_HIGH;
			end
		end

		if (i_gc_reset)
		begin
			cfg_d = tfq_pkg::CFG_RST;
			oneshot_d = 1'b0;
			alarm_d = 1'b0;
			expect_d = tfq_pkg::EXPECT_HIGH;
		end

		conv_run_d = !cfg_d[tfq_pkg::SHUTDOWN_BIT_POS] || oneshot_d;
		alert_d = cfg_d[tfq_pkg::ALARM_POLARITY_BIT_POS]
			? alarm_d : !alarm_d;
	end

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			temp_q <= tfq_pkg::TEMP_RST;
			tlow_q <= tfq_pkg::TLOW_RST;
			thigh_q <= tfq_pkg::THIGH_RST;
			cfg_q <= tfq_pkg::CFG_RST;
			new_q <= 1'b0;
			oneshot_q <= 1'b0;
			conv_run_q <= 1'b1;
			alarm_q <= 1'b0;
			expect_q <= tfq_pkg::EXPECT_HIGH;
			rdata_q <= tfq_pkg::RDATA_IDLE;
			alert_q <= 1'b1;
		end
		else
		begin
			temp_q <= temp_d;
			tlow_q <= tlow_d;
			thigh_q <= thigh_d;
			cfg_q <= cfg_d;
			new_q <= new_d;
			oneshot_q <= oneshot_d;
			conv_run_q <= conv_run_d;
			alarm_q <= alarm_d;
			expect_q <= expect_d;
			rdata_q <= rdata_d;
			alert_q <= alert_d;
		end
	end

	assign o_rdata = rdata_q;
	assign o_conv_run = conv_run_q;
	assign o_alert = alert_q;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	AST_STORE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		i_conv_valid && conv_run_q |=> new_q)
		else $error("completed conversion was not stored");

	AST_TEMP_READ: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		i_rd && i_addr == tfq_pkg::ADDR_TEMP
		|=> o_rdata == {$past(temp_q), tfq_pkg::FRAC_ZERO})
		else $error("result read did not return the stored value");

	AST_RES_MASK: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		new_q |-> (temp_q & ~tfq_pkg::res_mask($past(resolution_sel)))
		== 12'h000)
		else $error("stored result wider than the resolution");

	AST_GC_DEFAULTS: assert property (@(posedge i_ref_clk)
		disable iff (!i_resetn)
		i_gc_reset |=> cfg_q == tfq_pkg::CFG_RST && !alarm_q)
		else $error("general call reset did not restore defaults");

	AST_POLARITY: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		o_alert == (alarm_polarity_bit ? alarm_q : !alarm_q))
		else $error("alert pin level does not match polarity");

	AST_CMP_SET: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		!thermostat_mode_bit && fault_valid && is_high && !i_gc_reset
		|=> alarm_q)
		else $error("comparator alarm did not set on high fault");

	AST_CMP_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		!thermostat_mode_bit && fault_valid && is_low && !is_high
		|=> !alarm_q)
		else $error("comparator alarm did not clear on low fault");

	AST_CMP_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		!thermostat_mode_bit && !fault_valid && !i_gc_reset
		|=> alarm_q == $past(alarm_q))
		else $error("comparator alarm moved without a fault");

	AST_INT_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		thermostat_mode_bit && (i_rd || i_ara_ack) && !fault_valid
		|=> !alarm_q)
		else $error("interrupt alarm not cleared by read or answer");

	// a clear in the same cycle must not swallow a new event
	AST_INT_FAULT_WINS: assert property
		(@(posedge i_ref_clk) disable iff (!i_resetn)
		thermostat_mode_bit && fault_valid && is_high && !i_gc_reset
		&& expect_q == tfq_pkg::EXPECT_HIGH |=> alarm_q)
		else $error("interrupt event lost to a clear in the same cycle");

	AST_INT_SD_CLEAR: assert property
		(@(posedge i_ref_clk) disable iff (!i_resetn)
		thermostat_mode_bit && sd_entry && !fault_valid |=> !alarm_q)
		else $error("shutdown entry did not clear the interrupt alarm");

	AST_RDATA_IDLE: assert property
		(@(posedge i_ref_clk) disable iff (!i_resetn)
		!i_rd |=> o_rdata == tfq_pkg::RDATA_IDLE)
		else $error("read data stood longer than one cycle");

	AST_HALT_HOLDS: assert property
		(@(posedge i_ref_clk) disable iff (!i_resetn)
		i_conv_valid && !conv_run_q |=> temp_q == $past(temp_q))
		else $error("result changed while conversions were stopped");

endmodule : tfq_alarm_core

// *** hdl/tfq_pkg.sv ***
package tfq_pkg;

	// -----------------------------------------------------------------
	// register offsets
	// -----------------------------------------------------------------
	localparam logic [1:0] ADDR_TEMP = 2'h0;
	localparam logic [1:0] ADDR_CFG = 2'h1;
	localparam logic [1:0] ADDR_TLOW = 2'h2;
	localparam logic [1:0] ADDR_THIGH = 2'h3;

	// -----------------------------------------------------------------
	// configuration byte layout (upper byte of the 16-bit register)
	// -----------------------------------------------------------------
	localparam int SHUTDOWN_BIT_POS = 0;
	localparam int THERMOSTAT_MODE_BIT_POS = 1;
	localparam int ALARM_POLARITY_BIT_POS = 2;
	localparam int FAULT_QUEUE_LO_BIT_POS = 3;
	localparam int FAULT_QUEUE_HI_BIT_POS = 4;
	localparam int RESOLUTION_LO_BIT_POS = 5;
	localparam int RESOLUTION_HI_BIT_POS = 6;
	localparam int ONE_SHOT_BIT_POS = 7;

	// -----------------------------------------------------------------
	// reset values and widths
	// -----------------------------------------------------------------
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] CFG_LOW_BYTE = 8'h00;
	localparam logic [11:0] TEMP_RST = 12'h000;
	localparam logic [11:0] TLOW_RST = 12'h4B0;
	localparam logic [11:0] THIGH_RST = 12'h500;
	localparam logic [3:0] FRAC_ZERO = 4'h0;
	localparam logic [15:0] RDATA_IDLE = 16'h0000;
	localparam logic [2:0] FCNT_MAX = 3'h7;

	typedef enum logic [0:0]
	{
		EXPECT_HIGH = 1'b0,
		EXPECT_LOW = 1'b1
	} tfq_expect_t;

	// keeps only the bits that the selected resolution carries
	function automatic logic [11:0] res_mask(input logic [1:0] res);
		logic [11:0] m;
		m = 12'hFF8;
		case (res)
			2'h0: m = 12'hFF8;
			2'h1: m = 12'hFFC;
			2'h2: m = 12'hFFE;
			2'h3: m = 12'hFFF;
			default: m = 12'hFF8;
		endcase
		return m;
	endfunction : res_mask

	// consecutive faults needed for a valid fault condition
	function automatic logic [2:0] queue_thr(input logic [1:0] sel);
		logic [2:0] t;
		t = 3'h1;
		case (sel)
			2'h0: t = 3'h1;
			2'h1: t = 3'h2;
			2'h2: t = 3'h4;
			2'h3: t = 3'h6;
			default: t = 3'h1;
		endcase
		return t;
	endfunction : queue_thr

endpackage : tfq_pkg

// *** hdl/tfq_limit_compare.sv ***
`timescale 1ns/1ps
module tfq_limit_compare
(
	input wire logic [11:0] i_temp,
	input wire logic [11:0] i_thigh,
	input wire logic [11:0] i_tlow,
	output logic o_high,
	output logic o_low
);

	// -----------------------------------------------------------------
	// signed compare, both limits always checked
	// -----------------------------------------------------------------
	always_comb
	begin
		o_high = $signed(i_temp) >= $signed(i_thigh);
		o_low = $signed(i_temp) <= $signed(i_tlow);
	end

endmodule : tfq_limit_compare

// *** hdl/tfq_fault_queue.sv ***
`timescale 1ns/1ps
module tfq_fault_queue
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic i_clear,
	input wire logic i_sample,
	input wire logic i_fault,
	input wire logic [1:0] i_queue_sel,
	output logic o_valid
);

	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic [2:0] cnt_inc;

	// -----------------------------------------------------------------
	// consecutive fault counter
	// -----------------------------------------------------------------
	// shutdown is not an input here, so the count survives it
	always_comb
	begin
		cnt_inc = (cnt_q == tfq_pkg::FCNT_MAX) ? cnt_q : cnt_q + 3'h1;
		cnt_d = cnt_q;
		o_valid = 1'b0;
		if (i_clear)
			cnt_d = 3'h0;
		else if (i_sample)
		begin
			if (i_fault)
			begin
				cnt_d = cnt_inc;
				o_valid = cnt_inc >= tfq_pkg::queue_thr(i_queue_sel);
			end
			else
				cnt_d = 3'h0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			cnt_q <= 3'h0;
		else
			cnt_q <= cnt_d;
	end

	AST_FQ_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		i_sample && !i_fault |=> cnt_q == 3'h0)
		else $error("fault count not cleared after a good result");

	AST_FQ_SINGLE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		i_sample && i_fault && !i_clear && i_queue_sel == 2'h0 |-> o_valid)
		else $error("queue of one did not give a valid fault");

endmodule : tfq_fault_queue

// *** dv/tfq_host_model.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// host side: register master plus converter and bus events
// ---------------------------------------------------------------
module tfq_host_model
(
	input wire logic i_ref_clk,
	input wire logic [15:0] i_rdata,
	output logic [1:0] o_addr,
	output logic [15:0] o_wdata,
	output logic o_wr,
	output logic o_rd,
	output logic o_conv_valid,
	output logic [11:0] o_conv_data,
	output logic o_gc_reset,
	output logic o_ara_ack
);
	// called once at time zero, before reset is released
	task automatic idle;
		o_addr <= 2'h0;
		o_wdata <= 16'h0000;
		o_wr <= 1'h0;
		o_rd <= 1'h0;
		o_conv_valid <= 1'h0;
		o_conv_data <= 12'h000;
		o_gc_reset <= 1'h0;
		o_ara_ack <= 1'h0;
	endtask : idle

	// released data lines show the inverse so stale values never match
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge i_ref_clk);
		o_wr <= 1'h1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_ref_clk);
		o_wr <= 1'h0;
		o_wdata <= ~d;
		#1;
	endtask : wr

	task automatic rd(input logic [1:0] a, output logic [15:0] d);
		@(posedge i_ref_clk);
		o_rd <= 1'h1;
		o_addr <= a;
		@(posedge i_ref_clk);
		o_rd <= 1'h0;
		#1;
		d = i_rdata;
	endtask : rd

	// alarm settles one edge after the taking edge
	task automatic conv(input logic [11:0] t);
		@(posedge i_ref_clk);
		o_conv_valid <= 1'h1;
		o_conv_data <= t;
		@(posedge i_ref_clk);
		o_conv_valid <= 1'h0;
		o_conv_data <= ~t;
		repeat (2) @(posedge i_ref_clk);
		#1;
	endtask : conv

	// gc high: general call reset, else alert response answered
	task automatic ev(input logic gc);
		@(posedge i_ref_clk);
		o_gc_reset <= gc;
		o_ara_ack <= ~gc;
		@(posedge i_ref_clk);
		o_gc_reset <= 1'h0;
		o_ara_ack <= 1'h0;
		@(posedge i_ref_clk);
		#1;
	endtask : ev
endmodule : tfq_host_model

// *** dv/test_temp_alarm_fault_queue.sv ***
`timescale 1ns/1ps
module test_temp_alarm_fault_queue;
	typedef struct packed
	{
		logic [7:0] cfg;
		logic [11:0] t;
		logic [3:0] n;
		logic [15:0] r;
		logic a;
	} tfq_row_t;

	logic i_ref_clk;
	logic i_resetn;
	logic [1:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [15:0] d;
	logic [11:0] cdata;
	logic wr, rd, cv, run, gc, ara, alert;
	int num_errors = 0;
	int cmp_count = 0;
	// config byte, result, conversions, result read back, alarm pin
	tfq_row_t rows [19] = '{
		'{8'h00, 12'h123, 4'h1, 16'h1200, 1'h1},
		'{8'h20, 12'h127, 4'h1, 16'h1240, 1'h1},
		'{8'h40, 12'h127, 4'h1, 16'h1260, 1'h1},
		'{8'h60, 12'h127, 4'h1, 16'h1270, 1'h1},
		'{8'h60, 12'h500, 4'h1, 16'h5000, 1'h0},
		'{8'h60, 12'h4C0, 4'h1, 16'h4C00, 1'h0},
		'{8'h60, 12'hE70, 4'h1, 16'hE700, 1'h1},
		'{8'h64, 12'h100, 4'h1, 16'h1000, 1'h0},
		'{8'h64, 12'h600, 4'h1, 16'h6000, 1'h1},
		'{8'h6C, 12'h4C0, 4'h1, 16'h4C00, 1'h1},
		'{8'h6C, 12'h4C0, 4'h1, 16'h4C00, 1'h1},
		'{8'h6C, 12'h100, 4'h1, 16'h1000, 1'h1},
		'{8'h6C, 12'h100, 4'h1, 16'h1000, 1'h0},
		'{8'h74, 12'h4C0, 4'h1, 16'h4C00, 1'h0},
		'{8'h74, 12'h600, 4'h3, 16'h6000, 1'h0},
		'{8'h74, 12'h600, 4'h1, 16'h6000, 1'h1},
		'{8'h7C, 12'h4C0, 4'h1, 16'h4C00, 1'h1},
		'{8'h7C, 12'h100, 4'h5, 16'h1000, 1'h1},
		'{8'h7C, 12'h100, 4'h1, 16'h1000, 1'h0}};
	logic [15:0] rst_val [4] = '{16'h0000, 16'h0000, 16'h4B00, 16'h5000};

	tfq_alarm_core dut
	(
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_addr(addr),
		.i_wdata(wdata),
		.i_wr(wr),
		.i_rd(rd),
		.o_rdata(rdata),
		.i_conv_valid(cv),
		.i_conv_data(cdata),
		.o_conv_run(run),
		.i_gc_reset(gc),
		.i_ara_ack(ara),
		.o_alert(alert)
	);

	tfq_host_model host
	(
		.i_ref_clk(i_ref_clk),
		.i_rdata(rdata),
		.o_addr(addr),
		.o_wdata(wdata),
		.o_wr(wr),
		.o_rd(rd),
		.o_conv_valid(cv),
		.o_conv_data(cdata),
		.o_gc_reset(gc),
		.o_ara_ack(ara)
	);

	// ---------------------------------------------------------------
	// checking and verdict
	// ---------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check

	task automatic ck1(input logic seen, input logic exp);
		check({15'h0000, seen}, {15'h0000, exp});
	endtask : ck1

	task automatic print_verdict;
		if (num_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	initial
	begin
		i_ref_clk = 1'h0;
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end

	initial
	begin
		repeat (20000) @(posedge i_ref_clk);
		num_errors++;
		print_verdict();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		i_resetn = 1'h0;
		host.idle();
		repeat (3) @(posedge i_ref_clk);
		i_resetn <= 1'h1;
		foreach (rows[i])
		begin
			host.wr(tfq_pkg::ADDR_CFG, {rows[i].cfg, 8'h00});
			repeat (rows[i].n) host.conv(rows[i].t);
			ck1(alert, rows[i].a);
			host.rd(tfq_pkg::ADDR_TEMP, d);
			check(d, rows[i].r);
		end
		// counter must survive shutdown; results refused while stopped
		host.wr(tfq_pkg::ADDR_CFG, 16'h6C00);
		host.conv(12'h4C0);
		host.conv(12'h600);
		ck1(alert, 1'h0);
		host.wr(tfq_pkg::ADDR_CFG, 16'h6D00);
		ck1(run, 1'h0);
		host.conv(12'h100);
		host.rd(tfq_pkg::ADDR_TEMP, d);
		check(d, 16'h6000);
		@(posedge i_ref_clk);
		#1;
		check(rdata, 16'h0000);
		host.wr(tfq_pkg::ADDR_CFG, 16'h6C00);
		host.conv(12'h600);
		ck1(alert, 1'h1);
		host.rd(tfq_pkg::ADDR_TLOW, d);
		check(d, 16'h4B00);
		host.wr(tfq_pkg::ADDR_TLOW, 16'h4B00);
		host.wr(tfq_pkg::ADDR_CFG, 16'h6D00);
		ck1(alert, 1'h1);
		host.ev(1'h1);
		ck1(alert, 1'h1);
		host.rd(tfq_pkg::ADDR_CFG, d);
		check(d, 16'h0000);
		// interrupt mode: alternate events, each cleared
		host.wr(tfq_pkg::ADDR_CFG, 16'h0200);
		host.conv(12'h600);
		ck1(alert, 1'h0);
		host.rd(tfq_pkg::ADDR_TEMP, d);
		@(posedge i_ref_clk);
		#1;
		ck1(alert, 1'h1);
		host.conv(12'h600);
		ck1(alert, 1'h1);
		host.conv(12'h100);
		ck1(alert, 1'h0);
		host.ev(1'h0);
		ck1(alert, 1'h1);
		host.conv(12'h600);
		ck1(alert, 1'h0);
		host.wr(tfq_pkg::ADDR_CFG, 16'h0300);
		ck1(alert, 1'h1);
		host.wr(tfq_pkg::ADDR_CFG, 16'h0200);
		host.conv(12'h100);
		ck1(alert, 1'h0);
		host.wr(tfq_pkg::ADDR_CFG, 16'h0000);
		host.conv(12'h4C0);
		ck1(alert, 1'h0);
		host.conv(12'h100);
		ck1(alert, 1'h1);
		// new limits, high kept above low
		host.wr(tfq_pkg::ADDR_THIGH, 16'h190F);
		host.wr(tfq_pkg::ADDR_TLOW, 16'h0A00);
		host.rd(tfq_pkg::ADDR_THIGH, d);
		check(d, 16'h1900);
		host.conv(12'h190);
		ck1(alert, 1'h0);
		host.conv(12'h0A7);
		ck1(alert, 1'h1);
		host.wr(tfq_pkg::ADDR_TEMP, 16'hFFF0);
		host.rd(tfq_pkg::ADDR_TEMP, d);
		check(d, 16'h0A00);
		// second reset in mid-run
		@(posedge i_ref_clk);
		i_resetn <= 1'h0;
		repeat (3) @(posedge i_ref_clk);
		#1;
		ck1(alert, 1'h1);
		ck1(run, 1'h1);
		i_resetn <= 1'h1;
		for (int a = 0; a < 4; a++)
		begin
			host.rd(2'(a), d);
			check(d, rst_val[a]);
		end
		print_verdict();
	end
endmodule : test_temp_alarm_fault_queue
